// ==== rtl/lsf_consts.vh ====
// Constants for the load, store and flag execution block
`ifndef LSF_CONSTS_VH
`define LSF_CONSTS_VH

// ----------------
// Operation codes on CMD_OP
// ----------------
`define LSF_OP_NOP      6'h00
`define LSF_OP_BSTORE   6'h01
`define LSF_OP_BLOAD    6'h02
`define LSF_OP_FSET     6'h03
`define LSF_OP_FCLR     6'h04
`define LSF_OP_COPY     6'h05
`define LSF_OP_PCOPY    6'h06
`define LSF_OP_IMM      6'h07
`define LSF_OP_LDIND    6'h08
`define LSF_OP_STIND    6'h09
`define LSF_OP_LDDISP   6'h0A
`define LSF_OP_STDISP   6'h0B
`define LSF_OP_LDDIR    6'h0C
`define LSF_OP_STDIR    6'h0D
`define LSF_OP_PMREAD   6'h0E
`define LSF_OP_PMWRITE  6'h0F
`define LSF_OP_IORD     6'h10
`define LSF_OP_IOWR     6'h11
`define LSF_OP_PUSH     6'h12
`define LSF_OP_POP      6'h13
`define LSF_OP_SLEEP    6'h14
`define LSF_OP_WDOG     6'h15
`define LSF_OP_BREAK    6'h16

// ----------------
// Pointer modes and pointer selects
// ----------------
`define LSF_MODE_PLAIN  2'h0
`define LSF_MODE_INC    2'h1
`define LSF_MODE_DEC    2'h2
`define LSF_MODE_IMPL   2'h3
`define LSF_PTR_Y       2'h2
`define LSF_PTR_Z       2'h3
`define LSF_PAIR_BASE   2'h3

// ----------------
// Status flag bit positions
// ----------------
`define LSF_FLG_T       3'h6

// ----------------
// Register map and reset values
// ----------------
`define LSF_AXI_AW      8
`define LSF_REG_CTRL    8'h00
`define LSF_REG_STATUS  8'h04
`define LSF_REG_SP      8'h08
`define LSF_CTRL_RUN    0
`define LSF_ST_BUSY     8
`define LSF_ST_BAD      9
`define LSF_CTRL_RESET  1'b1
`define LSF_SP_RESET    16'h00FF
`define LSF_RESP_OKAY   2'h0
`define LSF_RESP_SLVERR 2'h2

`endif

// ==== rtl/lsf_regfile.v ====
// Thirty-two byte working register file with byte and pair write ports
`timescale 1ns/1ps
`default_nettype none
module lsf_regfile #(
  parameter NREG = 32
) (
  input  wire               clk,
  input  wire               rst_n,
  input  wire               wb_en,
  input  wire [4:0]         wb_idx,
  input  wire [7:0]         wb_data,
  input  wire               wp_en,
  input  wire [3:0]         wp_idx,
  input  wire [15:0]        wp_data,
  output wire [NREG*8-1:0]  flat
);
  // ----------------
  // One storage byte per entry
  // ----------------
  genvar i;
  generate
    for (i = 0; i < NREG; i = i + 1) begin : g_reg
      localparam [4:0] IDX = i;  // Entry index at port width
      reg [7:0] r;  // Entry contents
      // Byte write wins over the pair write on the same entry
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          r <= 8'h00;
        end else if (wb_en && wb_idx == IDX) begin
          r <= wb_data;
        end else if (wp_en && wp_idx == IDX[4:1]) begin
          r <= IDX[0] ? wp_data[15:8] : wp_data[7:0];
        end
      end
      assign flat[i*8 +: 8] = r;
    end
  endgenerate
endmodule
`default_nettype wire

// ==== rtl/lsf_axil_slave.v ====
// AXI4-Lite slave front end: handshakes, write strobe and read capture
`timescale 1ns/1ps
`default_nettype none
`include "lsf_consts.vh"
module lsf_axil_slave #(
  parameter AW = `LSF_AXI_AW
) (
  input  wire           clk,
  input  wire           rst_n,
  input  wire [AW-1:0]  awaddr,
  input  wire           awvalid,
  output wire           awready,
  input  wire [31:0]    wdata,
  input  wire [3:0]     wstrb,
  input  wire           wvalid,
  output wire           wready,
  output reg  [1:0]     bresp,
  output reg            bvalid,
  input  wire           bready,
  input  wire [AW-1:0]  araddr,
  input  wire           arvalid,
  output wire           arready,
  output reg  [31:0]    rdata,
  output reg  [1:0]     rresp,
  output reg            rvalid,
  input  wire           rready,
  output wire           wr_en,
  output reg  [AW-1:0]  wr_addr,
  output reg  [31:0]    wr_data,
  output reg  [3:0]     wr_strb,
  input  wire           wr_err,
  input  wire [31:0]    rd_data,
  input  wire           rd_err
);
  reg aw_hold;  // Write address captured
  reg w_hold;   // Write data captured

  // ----------------
  // Handshake outputs, held low until reset is released
  // ----------------
  assign awready = ~aw_hold & rst_n;
  assign wready  = ~w_hold & rst_n;
  assign wr_en   = aw_hold & w_hold & ~bvalid;
  assign arready = ~rvalid & rst_n;

  // Write channel capture and response
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      wr_addr <= {AW{1'b0}};
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `LSF_RESP_OKAY;
    end else begin
      if (awvalid && !aw_hold) begin
        aw_hold <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && !w_hold) begin
        w_hold  <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      // Register file applies the write in this cycle
      if (wr_en) begin
        aw_hold <= 1'b0;
        w_hold  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_err ? `LSF_RESP_SLVERR : `LSF_RESP_OKAY;
      end else if (bready) begin
        bvalid  <= 1'b0;
      end
    end
  end

  // Read channel: decode the live address and capture
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `LSF_RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_err ? `LSF_RESP_SLVERR : `LSF_RESP_OKAY;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/lsf_exec.v ====
// Execution unit for flag, move, load, store and control operations
// Notes on behaviour
// - Bit store copies register bit into T
// - Bit load writes T into register bit
// - Flag set or clear touches one flag
// - Post-increment load reads, then bumps pointer
// - Pre-decrement load drops pointer, then reads
// - Displaced load uses Y or Z plus offset
// - Direct load reads address from instruction
// - Post-increment store writes, then bumps pointer
// - Pre-decrement store drops pointer, then writes
// - Displaced store uses Y or Z plus offset
// - Direct store writes instruction address, two cycles
// - Program read via Z, three cycles, optional increment
// - Push stores register on stack, two cycles
// - Pop loads register from stack, two cycles
// - Nop, sleep, watchdog restart take one cycle
// - Break signals debug and clears run, halting execution
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lsf_consts.vh"
module lsf_exec #(
  parameter [15:0] SP_RESET = `LSF_SP_RESET,
  parameter        AW       = `LSF_AXI_AW
) (
  input  wire           CLK,
  input  wire           RESET_N,
  input  wire           CMD_VALID,
  output wire           CMD_READY,
  input  wire [5:0]     CMD_OP,
  input  wire [4:0]     CMD_RD,
  input  wire [4:0]     CMD_RR,
  input  wire [2:0]     CMD_BIT,
  input  wire [7:0]     CMD_IMM,
  input  wire [5:0]     CMD_DISP,
  input  wire [15:0]    CMD_ADDR,
  input  wire [1:0]     CMD_PTR,
  input  wire [1:0]     CMD_MODE,
  output reg  [15:0]    DM_ADDR,
  output reg            DM_RE,
  output reg            DM_WE,
  output reg  [7:0]     DM_WDATA,
  input  wire [7:0]     DM_RDATA,
  output reg  [15:0]    PM_ADDR,
  output reg            PM_RE,
  input  wire [7:0]     PM_RDATA,
  output reg            PM_WE,
  output reg  [15:0]    PM_WDATA,
  output wire [5:0]     IO_ADDR,
  output wire           IO_RE,
  input  wire [7:0]     IO_RDATA,
  output wire           IO_WE,
  output wire [7:0]     IO_WDATA,
  output reg            SLEEP_REQ,
  output reg            WDT_RESTART,
  output reg            DEBUG_BREAK,
  output wire [7:0]     STATUS_FLAGS,
  input  wire [AW-1:0]  S_AXI_AWADDR,
  input  wire           S_AXI_AWVALID,
  output wire           S_AXI_AWREADY,
  input  wire [31:0]    S_AXI_WDATA,
  input  wire [3:0]     S_AXI_WSTRB,
  input  wire           S_AXI_WVALID,
  output wire           S_AXI_WREADY,
  output wire [1:0]     S_AXI_BRESP,
  output wire           S_AXI_BVALID,
  input  wire           S_AXI_BREADY,
  input  wire [AW-1:0]  S_AXI_ARADDR,
  input  wire           S_AXI_ARVALID,
  output wire           S_AXI_ARREADY,
  output wire [31:0]    S_AXI_RDATA,
  output wire [1:0]     S_AXI_RRESP,
  output wire           S_AXI_RVALID,
  input  wire           S_AXI_RREADY
);
  // ----------------
  // States, one-hot
  // ----------------
  localparam [3:0] ST_IDLE = 4'b0001;  // Ready for a command
  localparam [3:0] ST_MEM  = 4'b0010;  // Data memory access cycle
  localparam [3:0] ST_PM1  = 4'b0100;  // First program read wait
  localparam [3:0] ST_PM2  = 4'b1000;  // Program byte captured

  // ----------------
  // Reset synchroniser
  // ----------------
  reg rst_meta;  // First stage, read only by the second
  reg rst_n;     // Released reset for the design
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------
  // State and architectural registers
  // ----------------
  reg  [3:0]   st;        // Current state
  reg  [7:0]   status_register;      // Status flags I T H S V N Z C
  reg  [15:0]  sp;        // Stack pointer
  reg          run;       // Software run enable
  reg          bad;       // Sticky malformed command flag
  reg  [4:0]   l_rd;      // Latched destination
  reg          l_load;    // Latched access is a read
  reg          l_inc;     // Latched post-increment request
  reg  [3:0]   l_pidx;    // Latched pointer pair index
  reg  [15:0]  l_ptr;     // Latched pointer value
  wire [255:0] rf;        // Register file contents

  // ----------------
  // Operand fetch and decode
  // ----------------
  wire take = CMD_VALID & CMD_READY;                 // Command accepted
  wire [7:0]  rd_val = rf[{CMD_RD, 3'b000} +: 8];    // Destination byte
  wire [7:0]  rr_val = rf[{CMD_RR, 3'b000} +: 8];    // Source byte
  wire [15:0] rr_pair = rf[{CMD_RR[4:1], 4'h0} +: 16];
  wire [3:0]  pidx = {`LSF_PAIR_BASE, CMD_PTR};      // Pointer pair index
  wire [15:0] ptr = rf[{pidx, 4'h0} +: 16];          // Selected pointer
  wire [15:0] zptr = rf[{`LSF_PAIR_BASE, `LSF_PTR_Z, 4'h0} +: 16];
  wire op_ind  = CMD_OP == `LSF_OP_LDIND || CMD_OP == `LSF_OP_STIND;
  wire op_disp = CMD_OP == `LSF_OP_LDDISP || CMD_OP == `LSF_OP_STDISP;
  wire op_mem  = op_ind || op_disp || CMD_OP == `LSF_OP_LDDIR ||
                 CMD_OP == `LSF_OP_STDIR || CMD_OP == `LSF_OP_PUSH ||
                 CMD_OP == `LSF_OP_POP;
  wire is_load = CMD_OP == `LSF_OP_LDIND || CMD_OP == `LSF_OP_LDDISP ||
                 CMD_OP == `LSF_OP_LDDIR || CMD_OP == `LSF_OP_POP;
  // Malformed: no pointer, implied mode, or displacement off X
  wire bad_cmd = (op_ind && (CMD_PTR == 2'h0 || CMD_MODE == `LSF_MODE_IMPL)) ||
                 (op_disp && !CMD_PTR[1]);
  wire predec = op_ind && CMD_MODE == `LSF_MODE_DEC;

  // Data memory address for each access form
  reg [15:0] addr_c;
  always @* begin
    case (CMD_OP)
      `LSF_OP_LDIND, `LSF_OP_STIND:
        addr_c = predec ? ptr - 16'h0001 : ptr;
      `LSF_OP_LDDISP, `LSF_OP_STDISP:
        addr_c = ptr + {10'h000, CMD_DISP};
      `LSF_OP_LDDIR, `LSF_OP_STDIR:
        addr_c = CMD_ADDR;
      `LSF_OP_PUSH:
        addr_c = sp;
      `LSF_OP_POP:
        addr_c = sp + 16'h0001;
      default:
        addr_c = 16'h0000;
    endcase
  end

  // ----------------
  // Port space strobes, live in the accept cycle
  // ----------------
  assign CMD_READY = st[0] & run;
  assign IO_ADDR   = CMD_ADDR[5:0];
  assign IO_RE     = take && CMD_OP == `LSF_OP_IORD;
  assign IO_WE     = take && CMD_OP == `LSF_OP_IOWR;
  assign IO_WDATA  = rr_val;
  assign STATUS_FLAGS = status_register;

  // ----------------
  // Register file write selection
  // ----------------
  reg        wb_en;    // Byte write enable
  reg [4:0]  wb_idx;   // Byte write index
  reg [7:0]  wb_data;  // Byte write data
  reg        wp_en;    // Pair write enable
  reg [3:0]  wp_idx;   // Pair write index
  reg [15:0] wp_data;  // Pair write data
  always @* begin
    wb_en   = 1'b0;
    wb_idx  = CMD_RD;
    wb_data = 8'h00;
    wp_en   = 1'b0;
    wp_idx  = pidx;
    wp_data = 16'h0000;
    if (st == ST_MEM || st == ST_PM2) begin
      // Load data lands at the end of the last cycle
      wb_en   = l_load;
      wb_idx  = l_rd;
      wb_data = (st == ST_PM2) ? PM_RDATA : DM_RDATA;
      wp_en   = l_inc;
      wp_idx  = l_pidx;
      wp_data = l_ptr + 16'h0001;
    end else if (take) begin
      case (CMD_OP)
        `LSF_OP_BLOAD: begin
          wb_en   = 1'b1;
          wb_data = (rd_val & ~(8'h01 << CMD_BIT)) |
                    ({7'h00, status_register[`LSF_FLG_T]} << CMD_BIT);
        end
        `LSF_OP_COPY: begin
          wb_en   = 1'b1;
          wb_data = rr_val;
        end
        `LSF_OP_PCOPY: begin
          wp_en   = 1'b1;
          wp_idx  = CMD_RD[4:1];
          wp_data = rr_pair;
        end
        `LSF_OP_IMM: begin
          wb_en   = 1'b1;
          wb_data = CMD_IMM;
        end
        `LSF_OP_IORD: begin
          wb_en   = 1'b1;
          wb_data = IO_RDATA;
        end
        default: begin
          wp_en   = predec && !bad_cmd;
          wp_data = addr_c;
        end
      endcase
    end
  end

  lsf_regfile #(
    .NREG (32)
  ) u_rf (
    .clk     (CLK),
    .rst_n   (rst_n),
    .wb_en   (wb_en),
    .wb_idx  (wb_idx),
    .wb_data (wb_data),
    .wp_en   (wp_en),
    .wp_idx  (wp_idx),
    .wp_data (wp_data),
    .flat    (rf)
  );

  // ----------------
  // Register bus
  // ----------------
  wire          wr_en;    // Write applied this cycle
  wire [AW-1:0] wr_addr;  // Write address
  wire [31:0]   wr_data;  // Write data
  wire [3:0]    wr_strb;  // Write byte lanes
  reg  [31:0]   rd_data;  // Read mux
  reg           rd_err;   // Unmapped read
  wire wr_ctrl = wr_en && wr_addr == `LSF_REG_CTRL;
  wire wr_stat = wr_en && wr_addr == `LSF_REG_STATUS;
  wire wr_sp   = wr_en && wr_addr == `LSF_REG_SP;
  wire wr_err  = !(wr_addr == `LSF_REG_CTRL || wr_addr == `LSF_REG_STATUS ||
                   wr_addr == `LSF_REG_SP);

  // Read decode on the live read address
  always @* begin
    rd_err  = 1'b0;
    rd_data = 32'h00000000;
    case (S_AXI_ARADDR)
      `LSF_REG_CTRL:   rd_data[`LSF_CTRL_RUN] = run;
      `LSF_REG_STATUS: rd_data[9:0] = {bad, ~st[0], status_register};
      `LSF_REG_SP:     rd_data[15:0] = sp;
      default:         rd_err = 1'b1;
    endcase
  end

  lsf_axil_slave #(
    .AW (AW)
  ) u_bus (
    .clk     (CLK),
    .rst_n   (rst_n),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_err  (wr_err),
    .rd_data (rd_data),
    .rd_err  (rd_err)
  );

  // ----------------
  // Sequencer, flags, stack pointer and memory strobes
  // ----------------
  always @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      st          <= ST_IDLE;
      status_register        <= 8'h00;
      sp          <= SP_RESET;
      run         <= `LSF_CTRL_RESET;
      bad         <= 1'b0;
      l_rd        <= 5'h00;
      l_load      <= 1'b0;
      l_inc       <= 1'b0;
      l_pidx      <= 4'h0;
      l_ptr       <= 16'h0000;
      DM_ADDR     <= 16'h0000;
      DM_RE       <= 1'b0;
      DM_WE       <= 1'b0;
      DM_WDATA    <= 8'h00;
      PM_ADDR     <= 16'h0000;
      PM_RE       <= 1'b0;
      PM_WE       <= 1'b0;
      PM_WDATA    <= 16'h0000;
      SLEEP_REQ   <= 1'b0;
      WDT_RESTART <= 1'b0;
      DEBUG_BREAK <= 1'b0;
    end else begin
      // Pulses last one cycle
      DM_RE       <= 1'b0;
      DM_WE       <= 1'b0;
      PM_WE       <= 1'b0;
      SLEEP_REQ   <= 1'b0;
      WDT_RESTART <= 1'b0;
      DEBUG_BREAK <= 1'b0;
      // Software writes first, so the core wins a collision
      if (wr_ctrl && wr_strb[0])
        run <= wr_data[`LSF_CTRL_RUN];
      if (wr_stat && wr_strb[0])
        status_register <= wr_data[7:0];
      if (wr_stat && wr_strb[1] && wr_data[`LSF_ST_BAD])
        bad <= 1'b0;
      if (wr_sp && wr_strb[0])
        sp[7:0] <= wr_data[7:0];
      if (wr_sp && wr_strb[1])
        sp[15:8] <= wr_data[15:8];
      case (st)
        ST_IDLE: begin
          if (take) begin
            l_rd   <= (CMD_MODE == `LSF_MODE_IMPL) ? 5'h00 : CMD_RD;
            l_load <= is_load || CMD_OP == `LSF_OP_PMREAD;
            l_inc  <= CMD_MODE == `LSF_MODE_INC &&
                      (op_ind || CMD_OP == `LSF_OP_PMREAD) && !bad_cmd;
            l_pidx <= (CMD_OP == `LSF_OP_PMREAD) ? {`LSF_PAIR_BASE, `LSF_PTR_Z} : pidx;
            l_ptr  <= (CMD_OP == `LSF_OP_PMREAD) ? zptr : ptr;
            if (bad_cmd)
              bad <= 1'b1;
            if (op_mem && !bad_cmd) begin
              st       <= ST_MEM;
              DM_ADDR  <= addr_c;
              DM_RE    <= is_load;
              DM_WE    <= !is_load;
              DM_WDATA <= rr_val;
            end
            case (CMD_OP)
              `LSF_OP_BSTORE: status_register[`LSF_FLG_T] <= rr_val[CMD_BIT];
              `LSF_OP_FSET:   status_register[CMD_BIT] <= 1'b1;
              `LSF_OP_FCLR:   status_register[CMD_BIT] <= 1'b0;
              `LSF_OP_PUSH:   sp <= sp - 16'h0001;
              `LSF_OP_POP:    sp <= sp + 16'h0001;
              `LSF_OP_PMREAD: begin
                st      <= ST_PM1;
                PM_ADDR <= zptr;
                PM_RE   <= 1'b1;
              end
              `LSF_OP_PMWRITE: begin
                PM_ADDR  <= zptr;
                PM_WDATA <= rf[15:0];
                PM_WE    <= 1'b1;
              end
              `LSF_OP_SLEEP:  SLEEP_REQ <= 1'b1;
              `LSF_OP_WDOG:   WDT_RESTART <= 1'b1;
              `LSF_OP_BREAK: begin
                DEBUG_BREAK <= 1'b1;
                run         <= 1'b0;
              end
              default: ;
            endcase
          end
        end
        ST_MEM: st <= ST_IDLE;
        ST_PM1: st <= ST_PM2;
        ST_PM2: begin
          st    <= ST_IDLE;
          PM_RE <= 1'b0;
        end
        default: st <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/lsf_exec_monitor.sv ====
// Timing and flag checker for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "lsf_consts.vh"
module lsf_exec_monitor (
  input wire logic       CLK,
  input wire logic       RESET_N,
  input wire logic       CMD_VALID,
  input wire logic       CMD_READY,
  input wire logic [5:0] CMD_OP,
  input wire logic [2:0] CMD_BIT,
  input wire logic       DM_RE,
  input wire logic       DM_WE,
  input wire logic       PM_RE,
  input wire logic       WDT_RESTART,
  input wire logic [7:0] STATUS_FLAGS
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Decoded accepts
  wire tk = CMD_VALID && CMD_READY;
  wire ld = tk && (CMD_OP == `LSF_OP_LDDIR || CMD_OP == `LSF_OP_POP);
  wire st = tk && (CMD_OP == `LSF_OP_STDIR || CMD_OP == `LSF_OP_PUSH);
  wire mv = tk && (CMD_OP == `LSF_OP_COPY || CMD_OP == `LSF_OP_BLOAD);
  a_load_timing: assert property (ld |=> DM_RE && !CMD_READY ##1 !DM_RE)
    else $error("load timing wrong");
  a_store_timing: assert property (st |=> DM_WE && !DM_RE ##1 !DM_WE)
    else $error("store timing wrong");
  a_prog_read: assert property (tk && CMD_OP == `LSF_OP_PMREAD
    |=> (PM_RE && !CMD_READY)[*2] ##1 !PM_RE) else $error("program read timing wrong");
  a_flag_set: assert property (tk && CMD_OP == `LSF_OP_FSET
    |=> STATUS_FLAGS == ($past(STATUS_FLAGS) | (8'h01 << $past(CMD_BIT)))) else $error("set");
  a_flag_clear: assert property (tk && CMD_OP == `LSF_OP_FCLR
    |=> STATUS_FLAGS == ($past(STATUS_FLAGS) & ~(8'h01 << $past(CMD_BIT)))) else $error("clr");
  a_bit_store: assert property (tk && CMD_OP == `LSF_OP_BSTORE
    |=> (STATUS_FLAGS & 8'hBF) == ($past(STATUS_FLAGS) & 8'hBF)) else $error("bit store");
  a_move_flags: assert property (mv |=> $stable(STATUS_FLAGS))
    else $error("move touched flags");
  a_wdog_pulse: assert property (tk && CMD_OP == `LSF_OP_WDOG
    |=> WDT_RESTART ##1 !WDT_RESTART) else $error("watchdog pulse wrong");
  c_prog: cover property (tk && CMD_OP == `LSF_OP_PMREAD);
  c_store: cover property (st);
  c_break: cover property (tk && CMD_OP == `LSF_OP_BREAK);
endmodule
bind lsf_exec lsf_exec_monitor lsf_exec_monitor_inst (.*);
`default_nettype wire

// ==== verification/lsf_mem_model.sv ====
// Data, program and port spaces behind the execution block
`timescale 1ns/1ps
`default_nettype none
module lsf_mem_model (
  input  wire logic        clk,
  input  wire logic [15:0] dm_addr,
  input  wire logic        dm_re,
  input  wire logic        dm_we,
  input  wire logic [7:0]  dm_wdata,
  output logic      [7:0]  dm_rdata,
  input  wire logic [15:0] pm_addr,
  input  wire logic        pm_re,
  input  wire logic        pm_we,
  input  wire logic [15:0] pm_wdata,
  output logic      [7:0]  pm_rdata,
  input  wire logic [5:0]  io_addr,
  input  wire logic        io_re,
  input  wire logic        io_we,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata
);
  logic [7:0]  dm [0:255]; // Low data page
  logic [7:0]  io [0:63];  // Port space
  logic [15:0] pm_last;    // Last program word
  initial for (int i = 0; i < 256; i++) dm[i] = i[7:0] ^ 8'h3C;
  initial for (int i = 0; i < 64; i++) io[i] = i[7:0] ^ 8'hC3;
  // Unstrobed reads show inverted data, or the inverted address for program space
  assign dm_rdata = dm_re ? dm[dm_addr[7:0]] : ~dm[dm_addr[7:0]];
  assign pm_rdata = pm_re ? (pm_addr[7:0] ^ 8'h96) : ~pm_addr[7:0];
  assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];
  // Writes land on the strobed edge
  always @(posedge clk) begin
    if (dm_we) dm[dm_addr[7:0]] <= dm_wdata;
    if (io_we) io[io_addr] <= io_wdata;
    if (pm_we) pm_last <= pm_wdata;
  end
endmodule
`default_nettype wire

// ==== verification/cpu_load_store_flag_ops_tb.sv ====
// Self-checking bench for the load, store and flag block
`timescale 1ns/1ps
`default_nettype none
`include "lsf_consts.vh"
module cpu_load_store_flag_ops_tb;
  logic        CLK = 0, RESET_N = 0, CMD_VALID = 0;
  logic [5:0]  CMD_OP = 0, CMD_DISP = 0;
  logic [4:0]  CMD_RD = 0, CMD_RR = 0;
  logic [2:0]  CMD_BIT = 0;
  logic [7:0]  CMD_IMM = 0, S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, got;
  logic [15:0] CMD_ADDR = 0;
  logic [1:0]  CMD_PTR = 0, CMD_MODE = 0;
  logic [31:0] S_AXI_WDATA = 0;
  logic [3:0]  S_AXI_WSTRB = 0;
  logic        S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
  logic        S_AXI_ARVALID = 0, S_AXI_RREADY = 0;
  wire         CMD_READY, DM_RE, DM_WE, PM_RE, PM_WE, IO_RE, IO_WE, SLEEP_REQ;
  wire         WDT_RESTART, DEBUG_BREAK, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  wire         S_AXI_ARREADY, S_AXI_RVALID;
  wire [15:0]  DM_ADDR, PM_ADDR, PM_WDATA;
  wire [7:0]   DM_WDATA, DM_RDATA, PM_RDATA, IO_RDATA, IO_WDATA, STATUS_FLAGS;
  wire [5:0]   IO_ADDR;
  wire [1:0]   S_AXI_BRESP, S_AXI_RRESP;
  wire [31:0]  S_AXI_RDATA;
  int          num_errors = 0, cmp_count = 0;
  lsf_exec lsf_exec_inst (.*);
  lsf_mem_model lsf_mem_model_inst (.clk(CLK), .dm_addr(DM_ADDR), .dm_re(DM_RE), .dm_we(DM_WE),
    .dm_wdata(DM_WDATA), .dm_rdata(DM_RDATA), .pm_addr(PM_ADDR), .pm_re(PM_RE), .pm_we(PM_WE),
    .pm_wdata(PM_WDATA), .pm_rdata(PM_RDATA), .io_addr(IO_ADDR), .io_re(IO_RE), .io_we(IO_WE),
    .io_wdata(IO_WDATA), .io_rdata(IO_RDATA));
  always #10 CLK = ~CLK;
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h3C;
  endfunction
  function automatic logic [7:0] mem(input logic [7:0] a);
    return lsf_mem_model_inst.dm[a];
  endfunction
  task automatic chk(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Offer one command, hold it until taken
  task automatic cmd(input logic [5:0] op, input logic [4:0] d, r, input logic [15:0] a,
                     input logic [1:0] p = 2'h0, m = 2'h0);
    @(posedge CLK);
    {CMD_OP, CMD_RD, CMD_RR, CMD_ADDR, CMD_PTR, CMD_MODE, CMD_IMM, CMD_BIT, CMD_DISP,
     CMD_VALID} <= {op, d, r, a, p, m, a[7:0], a[2:0], a[5:0], 1'b1};
    do @(negedge CLK); while (CMD_READY !== 1'b1);
    got = IO_WDATA;
    @(posedge CLK);
    CMD_VALID <= 1'b0;
  endtask
  task automatic reg_is(input logic [4:0] r, input logic [7:0] e);
    cmd(`LSF_OP_IOWR, 0, r, 16'h003F);
    chk(got, e, "register");
  endtask
  task automatic fl(input logic [7:0] e);
    @(negedge CLK);
    chk(STATUS_FLAGS, e, "flags");
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    {S_AXI_AWADDR, S_AXI_WDATA, S_AXI_WSTRB, S_AXI_AWVALID, S_AXI_WVALID,
     S_AXI_BREADY} <= {a, d, 4'hF, 3'b111};
    fork
      begin @(posedge CLK iff S_AXI_AWREADY); S_AXI_AWVALID <= 1'b0; end
      begin @(posedge CLK iff S_AXI_WREADY); S_AXI_WVALID <= 1'b0; end
    join
    @(posedge CLK iff S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    @(posedge CLK);
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} <= {a, 2'b11};
    @(posedge CLK iff S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    @(posedge CLK iff S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
    chk({S_AXI_RRESP, S_AXI_RDATA[29:0]}, {r, e[29:0]}, "axi read");
  endtask
  task automatic tally_and_finish;
    $display("Errors %0d, comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #100us;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    axi_rd(`LSF_REG_CTRL, 32'h1, `LSF_RESP_OKAY);
    axi_rd(`LSF_REG_SP, 32'hFF, `LSF_RESP_OKAY);
    axi_rd(8'h0C, 32'h0, `LSF_RESP_SLVERR);
    cmd(`LSF_OP_IMM, 16, 0, 16'hA5);
    cmd(`LSF_OP_COPY, 17, 16, 0);
    reg_is(17, 8'hA5);
    cmd(`LSF_OP_IMM, 17, 0, 16'h3C);
    cmd(`LSF_OP_PCOPY, 2, 16, 0);
    reg_is(3, 8'h3C);
    for (int b = 0; b < 8; b++) cmd(`LSF_OP_FSET, 0, 0, b[15:0]);
    fl(8'hFF);
    for (int b = 0; b < 8; b++) cmd(`LSF_OP_FCLR, 0, 0, b[15:0]);
    fl(8'h00);
    axi_wr(`LSF_REG_STATUS, 32'h80);
    cmd(`LSF_OP_BSTORE, 0, 16, 16'h5);
    fl(8'hC0);
    cmd(`LSF_OP_BLOAD, 18, 0, 16'h3);
    reg_is(18, 8'h08);
    cmd(`LSF_OP_IMM, 26, 0, 16'h10);
    cmd(`LSF_OP_IMM, 28, 0, 16'h20);
    cmd(`LSF_OP_IMM, 30, 0, 16'h30);
    cmd(`LSF_OP_LDIND, 19, 0, 0, 1, `LSF_MODE_INC);
    reg_is(19, pat(8'h10));
    reg_is(26, 8'h11);
    cmd(`LSF_OP_LDIND, 20, 0, 0, `LSF_PTR_Y, `LSF_MODE_DEC);
    reg_is(20, pat(8'h1F));
    cmd(`LSF_OP_LDDISP, 21, 0, 16'h5, `LSF_PTR_Z);
    reg_is(21, pat(8'h35));
    reg_is(30, 8'h30);
    cmd(`LSF_OP_LDDIR, 22, 0, 16'h40);
    reg_is(22, pat(8'h40));
    cmd(`LSF_OP_LDIND, 23, 0, 0, 1);
    reg_is(23, pat(8'h11));
    cmd(`LSF_OP_STIND, 0, 16, 0, 1, `LSF_MODE_INC);
    reg_is(26, 8'h12);
    cmd(`LSF_OP_STIND, 0, 16, 0, `LSF_PTR_Y, `LSF_MODE_DEC);
    reg_is(28, 8'h1E);
    cmd(`LSF_OP_STDISP, 0, 17, 16'h7, `LSF_PTR_Z);
    cmd(`LSF_OP_STDIR, 0, 16, 16'h50);
    cmd(`LSF_OP_PUSH, 0, 17, 0);
    axi_rd(`LSF_REG_SP, 32'hFE, `LSF_RESP_OKAY);
    cmd(`LSF_OP_POP, 24, 0, 0);
    reg_is(24, 8'h3C);
    chk(mem(8'h11) ^ mem(8'h1E), 8'h00, "inc/dec store");
    chk(mem(8'h37) ^ mem(8'h50), 8'h99, "disp/direct store");
    cmd(`LSF_OP_PMREAD, 0, 0, 0, `LSF_PTR_Z, `LSF_MODE_IMPL);
    cmd(`LSF_OP_PMREAD, 25, 0, 0, `LSF_PTR_Z, `LSF_MODE_INC);
    reg_is(0, 8'hA6);
    reg_is(25, 8'hA6);
    reg_is(30, 8'h31);
    cmd(`LSF_OP_IORD, 4, 0, 16'h3);
    reg_is(4, 8'hC0);
    cmd(`LSF_OP_PMWRITE, 0, 0, 0);
    cmd(`LSF_OP_SLEEP, 0, 0, 0);
    cmd(`LSF_OP_WDOG, 0, 0, 0);
    fl(8'hC0);
    cmd(`LSF_OP_LDIND, 5, 0, 0);
    axi_rd(`LSF_REG_STATUS, 32'h2C0, `LSF_RESP_OKAY);
    chk(lsf_mem_model_inst.pm_last, 32'hA6, "program write");
    cmd(`LSF_OP_BREAK, 0, 0, 0);
    fl(8'hC0);
    chk(CMD_READY, 32'h0, "ready after break");
    axi_wr(`LSF_REG_CTRL, 32'h1);
    cmd(`LSF_OP_NOP, 0, 0, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
